// ===== mcrd_decoder.sv
// APB command decoder of an energy meter: command, parameter and
// return-pointer registers, command execution and I/O point lookup.
// Assumes a zero-wait APB3 master and a raw button pin on button_press.
`timescale 1ns/1ps
module mcrd_decoder #(
    parameter int unsigned LOG_COUNT      = 3,
    parameter logic [31:0] TIMEOUT_CYCLES = 32'(mcrd_pkg::SETUP_TIMEOUT_CYCLES)
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic [15:0]           paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  button_press,
    output logic                       energy_clear,
    output logic                       cond_energy_clear,
    output logic                       incr_energy_clear,
    output logic                       input_meter_clear,
    output logic                       defaults_restore,
    output logic                       defaults_iec,
    output logic                       cond_accum_enable,
    output logic                       incr_interval_start,
    output logic      [LOG_COUNT-1:0]  log_trigger,
    output logic                       setup_mode,
    output logic                       setup_commit,
    output logic                       setup_discard,
    output logic                       setup_timeout,
    output logic      [15:0]           return_buffer_pointer,
    output logic      [15:0]           command_parameter,
    output logic                       io_target_valid,
    output mcrd_pkg::mcrd_io_group_t   io_target_group,
    output logic      [2:0]            io_target_position
);
    mcrd_setup_if sif ();

    logic [15:0] command_code;
    logic        last_unknown;
    logic        addr_ok;
    logic        hit_cmd;
    logic        hit_param;
    logic        hit_ptr;
    logic        hit_status;
    logic        mapped;
    logic        wr_en;
    logic        cmd_wr;
    logic [15:0] code;
    logic [31:0] next_rdata;
    logic        btn_meta;
    logic        btn_mid;
    logic        btn_last;
    logic        btn_level;
    logic        btn_prev;
    logic        btn_event;
    logic        code_known;
    logic        param_ok;

    // Register decode.

    assign addr_ok    = (paddr[1:0] == 2'b00);
    assign hit_cmd    = addr_ok && (paddr[15:2] == mcrd_pkg::IDX_CMD);
    assign hit_param  = addr_ok && (paddr[15:2] == mcrd_pkg::IDX_PARAM);
    assign hit_ptr    = addr_ok && (paddr[15:2] == mcrd_pkg::IDX_PTR);
    assign hit_status = addr_ok && (paddr[15:2] == mcrd_pkg::IDX_STATUS);
    assign mapped     = hit_cmd || hit_param || hit_ptr || hit_status;

    // Every access completes in its first access cycle.
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign wr_en   = psel && penable && pwrite && mapped;
    assign cmd_wr  = wr_en && hit_cmd;
    assign code    = pwdata[15:0];

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (hit_cmd)
            next_rdata[15:0] = command_code;
        else if (hit_param)
            next_rdata[15:0] = command_parameter;
        else if (hit_ptr)
            next_rdata[15:0] = return_buffer_pointer;
        else if (hit_status)
        begin
            next_rdata[mcrd_pkg::ST_COND]  = cond_accum_enable;
            next_rdata[mcrd_pkg::ST_SETUP] = setup_mode;
            next_rdata[mcrd_pkg::ST_UNK]   = last_unknown;
            next_rdata[mcrd_pkg::ST_POINT] = io_target_valid;
        end
    end

    // Read data is caught in the setup cycle so that prdata is a flop.
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata <= next_rdata;

    // Writable registers.

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            command_parameter <= mcrd_pkg::PARAM_RESET;
        else if (wr_en && hit_param)
            command_parameter <= pwdata[15:0];

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            command_code <= mcrd_pkg::CMD_RESET;
        else if (cmd_wr)
            command_code <= code;

    // Pointer values outside the return buffer are dropped rather than
    // clamped, so a bad write never moves data onto a foreign region.
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            return_buffer_pointer <= mcrd_pkg::PTR_RESET;
        else if (wr_en && hit_ptr &&
                 pwdata[15:0] >= mcrd_pkg::PTR_MIN &&
                 pwdata[15:0] <= mcrd_pkg::PTR_MAX)
            return_buffer_pointer <= pwdata[15:0];

    // Command classification.

    always_comb
    begin
        code_known = 1'b1;
        param_ok   = 1'b1;
        unique case (code)
            mcrd_pkg::CODE_CLR_ENERGY,
            mcrd_pkg::CODE_CLR_COND,
            mcrd_pkg::CODE_CLR_INCR,
            mcrd_pkg::CODE_CLR_INPUT,
            mcrd_pkg::CODE_COND_OFF,
            mcrd_pkg::CODE_COND_ON,
            mcrd_pkg::CODE_INCR_START,
            mcrd_pkg::CODE_LOG_MAP,
            mcrd_pkg::CODE_LOG_FILE,
            mcrd_pkg::CODE_SETUP_IN,
            mcrd_pkg::CODE_SETUP_OUT:
                param_ok = 1'b1;
            mcrd_pkg::CODE_DEFAULTS:
                param_ok = (command_parameter == mcrd_pkg::PARAM_IEEE) ||
                           (command_parameter == mcrd_pkg::PARAM_IEC);
            default:
                code_known = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            last_unknown <= 1'b0;
        else if (cmd_wr)
            last_unknown <= !(code_known && param_ok);

    // Command pulses, one cycle after the accepting write.

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            energy_clear        <= 1'b0;
            cond_energy_clear   <= 1'b0;
            incr_energy_clear   <= 1'b0;
            input_meter_clear   <= 1'b0;
            incr_interval_start <= 1'b0;
        end
        else
        begin
            energy_clear        <= cmd_wr && code == mcrd_pkg::CODE_CLR_ENERGY;
            cond_energy_clear   <= cmd_wr && code == mcrd_pkg::CODE_CLR_COND;
            incr_energy_clear   <= cmd_wr && code == mcrd_pkg::CODE_CLR_INCR;
            input_meter_clear   <= cmd_wr && code == mcrd_pkg::CODE_CLR_INPUT;
            incr_interval_start <= cmd_wr && code == mcrd_pkg::CODE_INCR_START;
        end

    // The region flag holds until the next restore so it may be read late.
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            defaults_restore <= 1'b0;
            defaults_iec     <= 1'b0;
        end
        else
        begin
            defaults_restore <= cmd_wr && code == mcrd_pkg::CODE_DEFAULTS && param_ok;
            if (cmd_wr && code == mcrd_pkg::CODE_DEFAULTS && param_ok)
                defaults_iec <= (command_parameter == mcrd_pkg::PARAM_IEC);
        end

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            cond_accum_enable <= 1'b0;
        else if (cmd_wr && code == mcrd_pkg::CODE_COND_ON)
            cond_accum_enable <= 1'b1;
        else if (cmd_wr && code == mcrd_pkg::CODE_COND_OFF)
            cond_accum_enable <= 1'b0;

    // One trigger flop per data log; file numbers count from one.
    genvar g;
    generate
        for (g = 0; g < LOG_COUNT; g++)
        begin : g_log
            always_ff @(posedge pclk or negedge presetn)
                if (!presetn)
                    log_trigger[g] <= 1'b0;
                else
                    log_trigger[g] <= cmd_wr &&
                        ((code == mcrd_pkg::CODE_LOG_MAP &&
                          command_parameter[g]) ||
                         (code == mcrd_pkg::CODE_LOG_FILE &&
                          command_parameter == 16'(g + 1)));
        end
    endgenerate

    // Setup session.

    assign sif.enter    = cmd_wr && code == mcrd_pkg::CODE_SETUP_IN;
    assign sif.leave    = cmd_wr && code == mcrd_pkg::CODE_SETUP_OUT;
    assign sif.save     = (command_parameter == mcrd_pkg::PARAM_SAVE);
    assign sif.activity = wr_en || btn_event;

    mcrd_setup_timer #(
        .TIMEOUT_CYCLES (TIMEOUT_CYCLES)
    ) u_setup_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .sif     (sif.timer)
    );

    assign setup_mode    = sif.active;
    assign setup_commit  = sif.commit;
    assign setup_discard = sif.discard;
    assign setup_timeout = sif.timeout;

    // Button pin: three flops, and a level change counts only once the
    // last two agree, which also rejects a single-cycle glitch.
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            btn_meta <= 1'b0;
            btn_mid  <= 1'b0;
            btn_last <= 1'b0;
        end
        else
        begin
            btn_meta <= button_press;
            btn_mid  <= btn_meta;
            btn_last <= btn_mid;
        end

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            btn_level <= 1'b0;
            btn_prev  <= 1'b0;
        end
        else
        begin
            if (btn_mid == btn_last)
                btn_level <= btn_last;
            btn_prev <= btn_level;
        end

    assign btn_event = btn_level && !btn_prev;

    // I/O point lookup, kept in step with the parameter register.

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            io_target_valid    <= 1'b0;
            io_target_group    <= mcrd_pkg::MCRD_IO_NONE;
            io_target_position <= 3'h0;
        end
        else if (wr_en && hit_param)
        begin
            io_target_valid    <= 1'b1;
            io_target_position <= 3'h0;
            if (pwdata[15:0] == mcrd_pkg::POINT_PULSE)
                io_target_group <= mcrd_pkg::MCRD_IO_BASE;
            else if (pwdata[15:0] == mcrd_pkg::POINT_STATUS)
            begin
                io_target_group    <= mcrd_pkg::MCRD_IO_BASE;
                io_target_position <= 3'h1;
            end
            else if (pwdata[15:0] >= mcrd_pkg::POINT_A_FIRST &&
                     pwdata[15:0] <  mcrd_pkg::POINT_B_FIRST)
            begin
                io_target_group    <= mcrd_pkg::MCRD_IO_A;
                io_target_position <= 3'(pwdata[15:0] - mcrd_pkg::POINT_A_FIRST);
            end
            else if (pwdata[15:0] >= mcrd_pkg::POINT_B_FIRST &&
                     pwdata[15:0] <= mcrd_pkg::POINT_LAST)
            begin
                io_target_group    <= mcrd_pkg::MCRD_IO_B;
                io_target_position <= 3'(pwdata[15:0] - mcrd_pkg::POINT_B_FIRST);
            end
            else
            begin
                io_target_valid <= 1'b0;
                io_target_group <= mcrd_pkg::MCRD_IO_NONE;
            end
        end
endmodule : mcrd_decoder

// ===== mcrd_pkg.sv
// Constants shared by the meter command decoder and its setup-session timer.
// Assumes a 20 MHz APB clock and 16-bit command words in the low data bits.
package mcrd_pkg;
    localparam int unsigned     CLK_HZ          = 20_000_000;
    localparam int unsigned     SETUP_TIMEOUT_S = 120;
    localparam longint unsigned SETUP_TIMEOUT_CYCLES =
        longint'(SETUP_TIMEOUT_S) * longint'(CLK_HZ);

    localparam int unsigned ADDR_W = 16;
    // Register indices; the byte address is four times the index.
    localparam logic [13:0] IDX_CMD    = 14'h1f40;
    localparam logic [13:0] IDX_PARAM  = 14'h1f41;
    localparam logic [13:0] IDX_PTR    = 14'h1f53;
    localparam logic [13:0] IDX_STATUS = 14'h1f60;

    localparam logic [15:0] PARAM_RESET = 16'h0000;
    localparam logic [15:0] CMD_RESET   = 16'h0000;
    localparam logic [15:0] PTR_RESET   = 16'h1f54;
    localparam logic [15:0] PTR_MIN     = 16'h1f54;
    localparam logic [15:0] PTR_MAX     = 16'h1fd5;

    localparam logic [15:0] CODE_CLR_ENERGY = 16'h1843;
    localparam logic [15:0] CODE_CLR_COND   = 16'h1844;
    localparam logic [15:0] CODE_CLR_INCR   = 16'h1845;
    localparam logic [15:0] CODE_CLR_INPUT  = 16'h1846;
    localparam logic [15:0] CODE_DEFAULTS   = 16'h1847;
    localparam logic [15:0] CODE_COND_OFF   = 16'h18b0;
    localparam logic [15:0] CODE_COND_ON    = 16'h18b1;
    localparam logic [15:0] CODE_INCR_START = 16'h1afe;
    localparam logic [15:0] CODE_LOG_MAP    = 16'h1d56;
    localparam logic [15:0] CODE_LOG_FILE   = 16'h1d57;
    localparam logic [15:0] CODE_SETUP_IN   = 16'h233c;
    localparam logic [15:0] CODE_SETUP_OUT  = 16'h233d;

    localparam logic [15:0] PARAM_IEEE = 16'h0001;
    localparam logic [15:0] PARAM_IEC  = 16'h0002;
    localparam logic [15:0] PARAM_SAVE = 16'h0001;

    localparam logic [15:0] POINT_PULSE   = 16'h0001;
    localparam logic [15:0] POINT_STATUS  = 16'h0002;
    localparam logic [15:0] POINT_A_FIRST = 16'h0003;
    localparam logic [15:0] POINT_B_FIRST = 16'h000b;
    localparam logic [15:0] POINT_LAST    = 16'h0012;

    localparam int unsigned ST_COND  = 0;
    localparam int unsigned ST_SETUP = 1;
    localparam int unsigned ST_UNK   = 2;
    localparam int unsigned ST_POINT = 3;

    typedef enum logic [1:0] {
        MCRD_IDLE  = 2'b00,
        MCRD_SETUP = 2'b01
    } mcrd_setup_state_t;

    typedef enum logic [1:0] {
        MCRD_IO_NONE = 2'b00,
        MCRD_IO_BASE = 2'b01,
        MCRD_IO_A    = 2'b10,
        MCRD_IO_B    = 2'b11
    } mcrd_io_group_t;
endpackage : mcrd_pkg

// ===== mcrd_setup_if.sv
// Carrier between the command decoder and the setup-session timer.
// Assumes both ends run on the same APB clock.
`timescale 1ns/1ps
interface mcrd_setup_if;
    logic enter;
    logic leave;
    logic save;
    logic activity;
    logic active;
    logic commit;
    logic discard;
    logic timeout;
    modport ctrl  (output enter, leave, save, activity,
                   input  active, commit, discard, timeout);
    modport timer (input  enter, leave, save, activity,
                   output active, commit, discard, timeout);
endinterface : mcrd_setup_if

// ===== mcrd_setup_timer.sv
// Setup-session state and the inactivity timeout that abandons it.
// Assumes enter, leave and activity are one-cycle pulses on pclk.
`timescale 1ns/1ps
module mcrd_setup_timer #(
    parameter logic [31:0] TIMEOUT_CYCLES = 32'(mcrd_pkg::SETUP_TIMEOUT_CYCLES)
) (
    input wire logic    pclk,
    input wire logic    presetn,
    mcrd_setup_if.timer sif
);
    mcrd_pkg::mcrd_setup_state_t state;
    logic [31:0]                 idle_count;
    logic                        expired;

    assign expired    = (idle_count >= TIMEOUT_CYCLES);
    assign sif.active = (state == mcrd_pkg::MCRD_SETUP);

    // A second enter while a session is open is ignored: one session at a time.
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            state <= mcrd_pkg::MCRD_IDLE;
        else
            unique case (state)
                mcrd_pkg::MCRD_IDLE:
                    if (sif.enter)
                        state <= mcrd_pkg::MCRD_SETUP;
                mcrd_pkg::MCRD_SETUP:
                    if (sif.leave || expired)
                        state <= mcrd_pkg::MCRD_IDLE;
            endcase

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            idle_count <= 32'h0000_0000;
        else if (!sif.active || sif.activity)
            idle_count <= 32'h0000_0000;
        else if (!expired)
            idle_count <= idle_count + 32'h0000_0001;

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            sif.commit  <= 1'b0;
            sif.discard <= 1'b0;
            sif.timeout <= 1'b0;
        end
        else
        begin
            sif.commit  <= sif.active && sif.leave && sif.save;
            sif.discard <= sif.active && (sif.leave ? !sif.save : expired);
            sif.timeout <= sif.active && !sif.leave && expired;
        end
endmodule : mcrd_setup_timer

// ===== mcrd_monitor.sv
// Checker for the meter command decoder, bound to its top module.
// Assumes zero-wait APB, so every access phase is the edge where a write lands.
`timescale 1ns/1ps
module mcrd_monitor #(
    parameter int unsigned LOG_COUNT = 3
) (
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic [15:0]          paddr,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [31:0]          pwdata,
    input wire logic                 energy_clear,
    input wire logic                 cond_energy_clear,
    input wire logic                 incr_energy_clear,
    input wire logic                 input_meter_clear,
    input wire logic                 cond_accum_enable,
    input wire logic                 incr_interval_start,
    input wire logic [LOG_COUNT-1:0] log_trigger,
    input wire logic                 setup_mode,
    input wire logic [15:0]          return_buffer_pointer,
    input wire logic [15:0]          command_parameter
);
    localparam logic [15:0] CMD_ADDR = {mcrd_pkg::IDX_CMD, 2'b00};
    default clocking mon_cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence cmd_wr(logic [15:0] code);
        psel && penable && pwrite && paddr == CMD_ADDR && pwdata[15:0] == code;
    endsequence

    clr_energy_a: assert property (cmd_wr(mcrd_pkg::CODE_CLR_ENERGY) |=> energy_clear)
        else $error("energy clear pulse missing");
    clr_cond_a: assert property (cmd_wr(mcrd_pkg::CODE_CLR_COND) |=> cond_energy_clear)
        else $error("conditional clear pulse missing");
    clr_incr_a: assert property (cmd_wr(mcrd_pkg::CODE_CLR_INCR) |=> incr_energy_clear)
        else $error("incremental clear pulse missing");
    clr_input_a: assert property (cmd_wr(mcrd_pkg::CODE_CLR_INPUT) |=> input_meter_clear)
        else $error("input clear pulse missing");
    cond_on_a: assert property (cmd_wr(mcrd_pkg::CODE_COND_ON) |=> cond_accum_enable)
        else $error("accumulation not started");
    cond_off_a: assert property (cmd_wr(mcrd_pkg::CODE_COND_OFF) |=> !cond_accum_enable)
        else $error("accumulation not stopped");
    interval_start_a: assert property (cmd_wr(mcrd_pkg::CODE_INCR_START) |=>
        incr_interval_start)
        else $error("interval start pulse missing");
    log_map_a: assert property (cmd_wr(mcrd_pkg::CODE_LOG_MAP) |=>
        log_trigger == $past(command_parameter[LOG_COUNT-1:0]))
        else $error("log triggers differ from bitmap");
    setup_enter_a: assert property (cmd_wr(mcrd_pkg::CODE_SETUP_IN) |=> setup_mode)
        else $error("setup mode not entered");
    ptr_range_a: assert property (return_buffer_pointer inside
        {[mcrd_pkg::PTR_MIN:mcrd_pkg::PTR_MAX]})
        else $error("return pointer out of range");
endmodule : mcrd_monitor

bind mcrd_decoder mcrd_monitor #(.LOG_COUNT(LOG_COUNT))
    mcrd_monitor_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .energy_clear(energy_clear),
    .cond_energy_clear(cond_energy_clear), .incr_energy_clear(incr_energy_clear),
    .input_meter_clear(input_meter_clear), .cond_accum_enable(cond_accum_enable),
    .incr_interval_start(incr_interval_start), .log_trigger(log_trigger),
    .setup_mode(setup_mode), .return_buffer_pointer(return_buffer_pointer),
    .command_parameter(command_parameter));

// ===== mcrd_apb_master.sv
// Remote master model: issues one APB transfer at a time.
// Assumes the slave answers with pready; the bench watchdog ends any hang.
`timescale 1ns/1ps
module mcrd_apb_master (
    input  wire logic        pclk,
    output logic      [15:0] paddr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h0000_0000;
    end

    // Commands are plain register writes, decoded by the device.
    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Address and write data are inverted on release so nothing relies on stale values.
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : mcrd_apb_master

// ===== tb_meter_command_register_decoder.sv
// Self-checking bench for the meter command decoder.
// Assumes the decoder top with a short setup timeout and the APB master model.
`timescale 1ns/1ps
module tb_meter_command_register_decoder;
    localparam logic [31:0] TMO = 32'h0000_0032;
    localparam logic [15:0] A_CMD = {mcrd_pkg::IDX_CMD, 2'b00};
    localparam logic [15:0] A_PAR = {mcrd_pkg::IDX_PARAM, 2'b00};
    localparam logic [15:0] A_PTR = {mcrd_pkg::IDX_PTR, 2'b00};
    localparam logic [15:0] A_ST  = {mcrd_pkg::IDX_STATUS, 2'b00};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, button_press, err_v;
    logic [15:0] paddr, return_buffer_pointer, command_parameter;
    logic [31:0] pwdata, prdata, v;
    logic energy_clear, cond_energy_clear, incr_energy_clear, input_meter_clear;
    logic defaults_restore, defaults_iec, cond_accum_enable, incr_interval_start;
    logic setup_mode, setup_commit, setup_discard, setup_timeout, io_target_valid;
    logic [2:0] log_trigger, io_target_position;
    mcrd_pkg::mcrd_io_group_t io_target_group;
    int fail_count = 0;
    int samples_checked = 0;
    int tmo_n = 0;
    wire [4:0] clrs = {energy_clear, cond_energy_clear, incr_energy_clear,
                       input_meter_clear, incr_interval_start};

    mcrd_decoder #(.LOG_COUNT(3), .TIMEOUT_CYCLES(TMO)) mcrd_decoder_inst (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .button_press(button_press), .energy_clear(energy_clear),
        .cond_energy_clear(cond_energy_clear), .incr_energy_clear(incr_energy_clear),
        .input_meter_clear(input_meter_clear), .defaults_restore(defaults_restore),
        .defaults_iec(defaults_iec), .cond_accum_enable(cond_accum_enable),
        .incr_interval_start(incr_interval_start), .log_trigger(log_trigger),
        .setup_mode(setup_mode), .setup_commit(setup_commit), .setup_discard(setup_discard),
        .setup_timeout(setup_timeout), .return_buffer_pointer(return_buffer_pointer),
        .command_parameter(command_parameter), .io_target_valid(io_target_valid),
        .io_target_group(io_target_group), .io_target_position(io_target_position));
    mcrd_apb_master mcrd_apb_master_inst (
        .pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    always @(posedge pclk) if (setup_timeout === 1'b1) tmo_n <= tmo_n + 1;

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Outputs are sampled 1 ns after the write edge, inside their one-cycle window.
    task wr(input logic [15:0] a, input logic [15:0] d);
        mcrd_apb_master_inst.xfer(1'b1, a, {16'h0000, d}, v, err_v);
        #1;
    endtask : wr

    task rd(input logic [15:0] a);
        mcrd_apb_master_inst.xfer(1'b0, a, 32'h0, v, err_v);
    endtask : rd

    // Only one command is ever outstanding, so no return region is shared.
    task t_regs;
        rd(A_PTR);
        check("ptr reset", v, {16'h0, mcrd_pkg::PTR_RESET});
        wr(A_PTR, mcrd_pkg::PTR_MAX);
        wr(A_PTR, 16'h1fd6);
        wr(A_PTR, 16'h1f53);
        rd(A_PTR);
        check("ptr kept", v, {16'h0, mcrd_pkg::PTR_MAX});
        rd(16'h7ff0);
        check("unmapped", {v[30:0], err_v}, 32'h1);
    endtask : t_regs

    task t_clears;
        logic [15:0] codes [5];
        codes = '{mcrd_pkg::CODE_CLR_ENERGY, mcrd_pkg::CODE_CLR_COND, mcrd_pkg::CODE_CLR_INCR,
                  mcrd_pkg::CODE_CLR_INPUT, mcrd_pkg::CODE_INCR_START};
        for (int i = 0; i < 5; i++)
        begin
            wr(A_CMD, codes[i]);
            check("clear pulse", 32'(clrs), 32'h10 >> i);
            @(posedge pclk);
            #1;
            check("clear end", 32'(clrs), 32'h0);
        end
    endtask : t_clears

    task t_cond;
        wr(A_CMD, mcrd_pkg::CODE_COND_ON);
        wr(A_CMD, 16'h1234);
        rd(A_ST);
        check("unknown kept", 32'({cond_accum_enable, v[2:0]}), 32'hd);
        wr(A_CMD, mcrd_pkg::CODE_COND_OFF);
        rd(A_ST);
        check("cond off", 32'({cond_accum_enable, v[2:0]}), 32'h0);
    endtask : t_cond

    task t_defaults;
        for (int p = 1; p < 4; p++)
        begin
            wr(A_PAR, 16'(p));
            wr(A_CMD, mcrd_pkg::CODE_DEFAULTS);
            check("defaults", 32'(defaults_restore), 32'(p < 3));
            if (p < 3) check("iec", 32'(defaults_iec), 32'(p == 2));
        end
    endtask : t_defaults

    task t_logs;
        for (int i = 0; i < 8; i++)
        begin
            wr(A_PAR, 16'(i));
            wr(A_CMD, mcrd_pkg::CODE_LOG_MAP);
            check("log map", 32'(log_trigger), 32'(i));
            wr(A_CMD, mcrd_pkg::CODE_LOG_FILE);
            check("log file", 32'(log_trigger), 32'(i > 0 && i < 4) << (i - 1));
        end
    endtask : t_logs

    task t_setup;
        wr(A_CMD, mcrd_pkg::CODE_SETUP_IN);
        check("setup in", 32'(setup_mode), 32'h1);
        wr(A_PAR, mcrd_pkg::PARAM_SAVE);
        wr(A_CMD, mcrd_pkg::CODE_SETUP_OUT);
        check("save", 32'({setup_mode, setup_commit, setup_discard}), 32'h2);
        wr(A_CMD, mcrd_pkg::CODE_SETUP_IN);
        wr(A_PAR, 16'h0002);
        wr(A_CMD, mcrd_pkg::CODE_SETUP_OUT);
        check("no save", 32'({setup_mode, setup_commit, setup_discard}), 32'h1);
        wr(A_CMD, mcrd_pkg::CODE_SETUP_IN);
        repeat (30) @(posedge pclk);
        button_press <= 1'b1;
        repeat (8) @(posedge pclk);
        button_press <= 1'b0;
        repeat (30) @(posedge pclk);
        #1;
        check("kept alive", 32'({setup_mode, tmo_n[1:0]}), 32'h4);
        repeat (40) @(posedge pclk);
        #1;
        check("timed out", 32'({setup_mode, tmo_n[1:0]}), 32'h1);
    endtask : t_setup

    function automatic logic [5:0] pt_exp(input logic [15:0] p);
        if (p == 16'h0001 || p == 16'h0002) return {3'b101, 3'(p - 16'h0001)};
        if (p >= 16'h0003 && p <= 16'h000a) return {3'b110, 3'(p - 16'h0003)};
        if (p >= 16'h000b && p <= 16'h0012) return {3'b111, 3'(p - 16'h000b)};
        return 6'h00;
    endfunction : pt_exp

    task t_points;
        logic [15:0] pts [8];
        pts = '{16'h0001, 16'h0002, 16'h0003, 16'h000a, 16'h000b, 16'h0012, 16'h0000, 16'h0013};
        for (int i = 0; i < 8; i++)
        begin
            wr(A_PAR, pts[i]);
            @(posedge pclk);
            #1;
            check("point", 32'({command_parameter, io_target_valid, io_target_group,
                  io_target_position}), 32'({pts[i], pt_exp(pts[i])}));
        end
    endtask : t_points

    task finish_test;
        if (fail_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    initial
    begin
        repeat (5000) @(posedge pclk);
        fail_count++;
        finish_test;
    end

    initial
    begin
        presetn = 1'b0;
        button_press = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_clears;
        t_cond;
        t_defaults;
        t_logs;
        t_setup;
        t_points;
        finish_test;
    end
endmodule : tb_meter_command_register_decoder
